// ---- logic/sgd_decoder.sv ----
// Scatter gather descriptor decoder with data block transfer
// Function
// - Type code 0 data, 1 bit bucket, 2 segment, 3 last, 4-E reserved, F vendor.
// - Data block bytes 7..0 give the 64-bit start byte address.
// - Bytes 11..8 give length in bytes; exactly that many are transferred.
// - Zero length moves no data and is a valid descriptor.
// - Address plus length above two to the 64 is an error.
// - Identifier bits 3..0 must be zero in a data block, otherwise an error.
// - Identifier bits 7..4 equal zero select data block parsing.
// - Reserved or unsupported type codes are descriptor errors.
// - Each descriptor is sixteen bytes; descriptor n spans n*16..n*16+15.
// - An all-zero descriptor is an accepted null descriptor moving nothing.
`timescale 1ns/1ps
`default_nettype none
module sgd_decoder (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [7:0] in_byte,
	output logic in_ready,
	output logic desc_valid,
	output sgd_pkg::sgd_desc_t desc,
	output logic xfer_valid,
	output logic [63:0] xfer_addr,
	output logic xfer_last
);
	typedef enum logic [2:0] {
		ST_COLLECT = 3'b001,
		ST_DECODE = 3'b010,
		ST_XFER = 3'b100
	} sgd_state_t;

	sgd_state_t state_r;
	sgd_state_t state_nxt;
	logic [7:0] buf_r [sgd_pkg::DESC_BYTES];
	logic [sgd_pkg::IDX_W-1:0] idx_r;
	logic take;
	logic start_xfer;
	sgd_pkg::sgd_desc_t dec;

	// Little-endian field assembly
	function automatic logic [63:0] le_field(input int base, input int n);
		logic [63:0] v;
		v = sgd_pkg::ADDR_NONE;
		for (int i = 0; i < 8; i++) begin
			if (i < n) begin
				v[i*8 +: 8] = buf_r[base + i];
			end
		end
		return v;
	endfunction : le_field

	assign take = in_valid && in_ready;

	// Byte capture, sixteen per descriptor
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idx_r <= '0;
			for (int i = 0; i < sgd_pkg::DESC_BYTES; i++) begin
				buf_r[i] <= sgd_pkg::BYTE_CLR;
			end
		end else if (take) begin
			buf_r[idx_r] <= in_byte;
			idx_r <= idx_r + 4'h1;
		end
	end

	// Field decode
	always_comb begin
		logic [7:0] id;
		logic [64:0] end_addr;
		id = buf_r[sgd_pkg::ID_BYTE];
		end_addr = '0;
		dec = '0;
		dec.dtype = id[sgd_pkg::TYPE_HI:sgd_pkg::TYPE_LO];
		dec.addr = le_field(sgd_pkg::ADDR_BYTE0, 8);
		dec.len = 32'(le_field(sgd_pkg::LEN_BYTE0, 4));
		dec.is_data = (dec.dtype == sgd_pkg::SGD_DATA_BLOCK);
		dec.err_type = (dec.dtype >= sgd_pkg::RSVD_LO)
			&& (dec.dtype <= sgd_pkg::RSVD_HI)
			|| (dec.dtype == sgd_pkg::SGD_VENDOR);
		end_addr = {1'b0, dec.addr} + {33'h0, dec.len};
		if (dec.is_data) begin
			dec.err_zero = (id[sgd_pkg::ZERO_HI:sgd_pkg::ZERO_LO]
				!= sgd_pkg::ZERO_OK);
			dec.err_range = (end_addr > sgd_pkg::ADDR_SPACE_END);
		end
		dec.err = dec.err_type || dec.err_zero || dec.err_range;
		dec.null_desc = dec.is_data && !dec.err
			&& (dec.len == sgd_pkg::LEN_NONE);
	end

	assign start_xfer = (state_r == ST_DECODE) && dec.is_data && !dec.err
		&& (dec.len != sgd_pkg::LEN_NONE);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_COLLECT: begin
				if (take && idx_r == sgd_pkg::IDX_LAST) begin
					state_nxt = ST_DECODE;
				end
			end
			ST_DECODE: begin
				state_nxt = start_xfer ? ST_XFER : ST_COLLECT;
			end
			ST_XFER: begin
				if (xfer_last) begin
					state_nxt = ST_COLLECT;
				end
			end
			default: begin
				state_nxt = ST_COLLECT;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= ST_COLLECT;
			in_ready <= 1'b1;
		end else begin
			state_r <= state_nxt;
			in_ready <= (state_nxt == ST_COLLECT);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			desc_valid <= 1'b0;
			desc <= '0;
		end else begin
			desc_valid <= (state_r == ST_DECODE);
			if (state_r == ST_DECODE) begin
				desc <= dec;
			end
		end
	end

	sgd_xfer u_xfer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(start_xfer),
		.start_addr(dec.addr),
		.start_len(dec.len),
		.xfer_valid(xfer_valid),
		.xfer_addr(xfer_addr),
		.xfer_last(xfer_last)
	);

	sequence last_byte_s;
		take && idx_r == sgd_pkg::IDX_LAST;
	endsequence
	sequence desc_out_s;
		##2 desc_valid;
	endsequence
	sequence good_block_s;
		desc_valid && desc.is_data && !desc.err
			&& desc.len != sgd_pkg::LEN_NONE;
	endsequence

	entry_size_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		last_byte_s |-> desc_out_s)
		else $error("descriptor not emitted after sixteen bytes");
	type_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		desc_valid |-> desc.dtype == $past(buf_r[15][7:4])
		&& desc.is_data == (desc.dtype == 4'h0))
		else $error("type code decoded wrongly");
	rsvd_type_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		desc_valid && desc.dtype >= 4'h4 |-> desc.err)
		else $error("reserved type not flagged");
	zero_field_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		desc_valid && desc.is_data && $past(buf_r[15][3:0]) != 4'h0
		|-> desc.err)
		else $error("nonzero zero field accepted");
	range_chk_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		desc_valid && desc.is_data |-> desc.err_range
		== (({1'b0, desc.addr} + {33'h0, desc.len}) > 65'h1_0000_0000_0000_0000))
		else $error("address range check wrong");
	le_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		desc_valid |-> desc.len[7:0] == $past(buf_r[8])
		&& desc.addr[63:56] == $past(buf_r[7]))
		else $error("field byte order wrong");
	null_ok_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		desc_valid && desc.dtype == 4'h0 && desc.addr == 64'h0
		&& desc.len == 32'h0 && $past(buf_r[15]) == 8'h00
		|-> desc.null_desc && !desc.err)
		else $error("null descriptor rejected");
	zero_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		desc_valid && desc.len == 32'h0 |-> (!xfer_valid)[*3])
		else $error("zero length moved data");
	first_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		good_block_s |=> xfer_valid && xfer_addr == $past(desc.addr))
		else $error("transfer not at block address");
endmodule : sgd_decoder
`default_nettype wire

// ---- logic/sgd_pkg.sv ----
// Shared constants and types for the descriptor decoder
package sgd_pkg;
	localparam int DESC_BYTES = 16;
	localparam int IDX_W = 4;
	localparam logic [3:0] IDX_LAST = 4'hF;
	localparam int ID_BYTE = 15;
	localparam int ADDR_BYTE0 = 0;
	localparam int LEN_BYTE0 = 8;
	localparam int TYPE_HI = 7;
	localparam int TYPE_LO = 4;
	localparam int ZERO_HI = 3;
	localparam int ZERO_LO = 0;
	localparam logic [3:0] ZERO_OK = 4'h0;
	localparam logic [31:0] LEN_NONE = 32'h0000_0000;
	localparam logic [63:0] ADDR_NONE = 64'h0000_0000_0000_0000;
	localparam logic [64:0] ADDR_SPACE_END = 65'h1_0000_0000_0000_0000;
	localparam logic [7:0] BYTE_CLR = 8'h00;

	typedef enum logic [3:0] {
		SGD_DATA_BLOCK = 4'h0,
		SGD_BIT_BUCKET = 4'h1,
		SGD_SEGMENT = 4'h2,
		SGD_LAST_SEGMENT = 4'h3,
		SGD_VENDOR = 4'hF
	} sgd_type_t;

	localparam logic [3:0] RSVD_LO = 4'h4;
	localparam logic [3:0] RSVD_HI = 4'hE;

	typedef struct packed {
		logic [3:0] dtype;
		logic is_data;
		logic err_type;
		logic err_zero;
		logic err_range;
		logic err;
		logic null_desc;
		logic [63:0] addr;
		logic [31:0] len;
	} sgd_desc_t;
endpackage : sgd_pkg

// ---- logic/sgd_xfer.sv ----
// Byte transfer sequencer for one accepted data block
`timescale 1ns/1ps
`default_nettype none
module sgd_xfer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [63:0] start_addr,
	input wire logic [31:0] start_len,
	output logic xfer_valid,
	output logic [63:0] xfer_addr,
	output logic xfer_last
);
	logic busy_r;
	logic [63:0] addr_r;
	logic [31:0] cnt_r;
	logic [31:0] beats_r;
	logic [31:0] len_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			addr_r <= sgd_pkg::ADDR_NONE;
			cnt_r <= sgd_pkg::LEN_NONE;
			len_r <= sgd_pkg::LEN_NONE;
		end else if (start) begin
			busy_r <= 1'b1;
			addr_r <= start_addr;
			cnt_r <= start_len;
			len_r <= start_len;
		end else if (busy_r) begin
			addr_r <= addr_r + 64'h1;
			cnt_r <= cnt_r - 32'h1;
			if (cnt_r == 32'h1) begin
				busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			xfer_valid <= 1'b0;
			xfer_addr <= sgd_pkg::ADDR_NONE;
			xfer_last <= 1'b0;
		end else begin
			xfer_valid <= busy_r;
			xfer_addr <= addr_r;
			xfer_last <= busy_r && (cnt_r == 32'h1);
		end
	end

	// Beats issued since start, for checking only
	always_ff @(posedge ref_clk) begin
		if (!rst_n || start) begin
			beats_r <= sgd_pkg::LEN_NONE;
		end else if (xfer_valid) begin
			beats_r <= beats_r + 32'h1;
		end
	end

	xfer_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		xfer_last |-> xfer_valid && (beats_r + 32'h1 == len_r))
		else $error("byte count differs from length");
	addr_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		xfer_valid && !xfer_last |=> xfer_valid
		&& xfer_addr == $past(xfer_addr) + 64'h1)
		else $error("transfer address not sequential");
endmodule : sgd_xfer
`default_nettype wire

// ---- test/sgd_host_mem.sv ----
// Host memory model offering descriptor bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module sgd_host_mem (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic [15:0] total,
	input wire logic in_ready,
	output logic in_valid,
	output logic [7:0] in_byte
);
	logic [7:0] mem [0:1023];
	logic [15:0] ptr_r;
	logic [15:0] ptr_nxt;
	assign ptr_nxt = (in_valid && in_ready) ? ptr_r + 16'h1 : ptr_r;
	initial begin
		in_valid = 1'b0;
		in_byte = 8'h00;
		ptr_r = 16'h0;
	end
	// Byte k of descriptor n sits at n*16+k
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ptr_r <= 16'h0;
			in_valid <= 1'b0;
		end else begin
			ptr_r <= ptr_nxt;
			if (in_valid && !in_ready) begin
				// Offer held until taken
			end else if (ptr_nxt < total && !stall) begin
				in_valid <= 1'b1;
				in_byte <= mem[ptr_nxt];
			end else begin
				in_valid <= 1'b0;
				in_byte <= ~in_byte;
			end
		end
	end
endmodule : sgd_host_mem
`default_nettype wire

// ---- test/sgd_decoder_tb.sv ----
// Self-checking bench for the descriptor decoder
`timescale 1ns/1ps
`default_nettype none
module sgd_decoder_tb;
	localparam int N = 60;
	localparam int LIMIT = 20000;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic stall = 1'b0;
	logic in_valid, in_ready, desc_valid, xfer_valid, xfer_last;
	logic [7:0] in_byte;
	logic [63:0] xfer_addr;
	logic [63:0] next_a = 64'h0;
	logic [31:0] left = 32'h0;
	sgd_pkg::sgd_desc_t desc;
	sgd_pkg::sgd_desc_t e;
	integer seed = 32'h9fd1;
	int err_count = 0;
	int n_compared = 0;
	int nd = 0;
	int cyc = 0;
	always #5 ref_clk = ~ref_clk;
	sgd_host_mem i_host (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
		.total(16'(N * 16)), .in_ready(in_ready), .in_valid(in_valid),
		.in_byte(in_byte));
	sgd_decoder i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .in_valid(in_valid),
		.in_byte(in_byte), .in_ready(in_ready), .desc_valid(desc_valid),
		.desc(desc), .xfer_valid(xfer_valid), .xfer_addr(xfer_addr),
		.xfer_last(xfer_last));
	task automatic check(input string name, input logic [127:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// Little-endian fields, reserved bytes left random
	task automatic put(input int d, input logic [63:0] a, input logic [31:0] l,
			input logic [7:0] id);
		for (int i = 0; i < 8; i++) i_host.mem[d * 16 + i] = a[i * 8 +: 8];
		for (int i = 0; i < 4; i++) i_host.mem[d * 16 + 8 + i] = l[i * 8 +: 8];
		i_host.mem[d * 16 + 15] = id;
	endtask : put
	function automatic sgd_pkg::sgd_desc_t exp_of(input int d);
		sgd_pkg::sgd_desc_t x;
		logic [7:0] id;
		x = '0;
		id = i_host.mem[d * 16 + 15];
		for (int i = 0; i < 8; i++) x.addr[i * 8 +: 8] = i_host.mem[d * 16 + i];
		for (int i = 0; i < 4; i++) x.len[i * 8 +: 8] = i_host.mem[d * 16 + 8 + i];
		x.dtype = id[7:4];
		x.is_data = id[7:4] == 4'h0;
		x.err_type = id[7:4] >= 4'h4;
		x.err_zero = x.is_data && id[3:0] != 4'h0;
		x.err_range = x.is_data &&
			({1'b0, x.addr} + {33'h0, x.len}) > 65'h1_0000_0000_0000_0000;
		x.err = x.err_type | x.err_zero | x.err_range;
		x.null_desc = x.is_data && !x.err && x.len == 32'h0;
		return x;
	endfunction : exp_of
	always @(negedge ref_clk) begin
		if (rst_n === 1'b1) begin
			// First beat follows the descriptor by one cycle
			check("xfer_valid", 128'(xfer_valid), 128'(left != 32'h0));
			if (xfer_valid === 1'b1) begin
				check("xfer_addr", 128'(xfer_addr), 128'(next_a));
				check("xfer_last", 128'(xfer_last), 128'(left == 32'h1));
				next_a = next_a + 64'h1;
				left = left - 32'h1;
			end
			if (desc_valid === 1'b1) begin
				e = exp_of(nd);
				check("desc", 128'(desc), 128'(e));
				if (e.is_data && !e.err && e.len != 32'h0) begin
					left = e.len;
					next_a = e.addr;
				end
				nd++;
			end
		end
	end
	always @(posedge ref_clk) begin
		stall <= (($random(seed) & 3) == 0);
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		for (int d = 0; d < N; d++) begin
			for (int b = 0; b < 16; b++) i_host.mem[d * 16 + b] = 8'($random(seed));
			// Every type code, then mostly data blocks
			put(d, {$random(seed), $random(seed)}, 32'($random(seed)) & 32'hF,
				d < 16 ? {4'(d), 4'h0} : (($random(seed) & 7) == 0) ?
				8'($random(seed)) : 8'h00);
		end
		for (int b = 0; b < 16; b++) i_host.mem[16 * 16 + b] = 8'h00;
		put(17, 64'hFFFF_FFFF_FFFF_FFFE, 32'h2, 8'h00);
		put(18, 64'hFFFF_FFFF_FFFF_FFFF, 32'h2, 8'h00);
		put(19, 64'h0000_0000_0000_1000, 32'h3, 8'h05);
		put(20, 64'h0000_0000_0000_1234, 32'h0, 8'h00);
		put(21, 64'h0123_4567_89AB_CDEF, 32'h0000_0103, 8'h00);
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		while (nd < N || left != 32'h0) @(posedge ref_clk);
		repeat (5) @(posedge ref_clk);
		end_of_test();
	end
endmodule : sgd_decoder_tb
`default_nettype wire
